// ---- src/odspi_pkg.sv ----
// Shared constants and types of the octal driver serial control port.
package odspi_pkg;
  localparam int          CH_NUM         = 8;
  localparam int          IN_NUM         = 4;
  localparam int          FRAME_BITS     = 16;
  localparam int          BYTE_BITS      = 8;
  localparam int          BUF_DEPTH      = 2;
  localparam logic [15:0] CMD_REG_RESET  = 16'hffff;
  localparam logic        TER_RESET      = 1'h1;
  localparam logic [1:0]  CMD_STANDBY    = 2'h0;
  localparam logic [1:0]  CMD_INPUT      = 2'h1;
  localparam logic [1:0]  CMD_ON         = 2'h2;
  localparam logic [1:0]  CMD_OFF        = 2'h3;
  localparam int          MCLK_MHZ       = 50;
  localparam int          OVL_FILTER_NS  = 3000;
  localparam int          OVL_FILTER_CYC = (OVL_FILTER_NS * MCLK_MHZ + 999)
                                           / 1000;
  localparam logic [7:0]  OVL_CNT_MAX    = 8'(OVL_FILTER_CYC);
  localparam logic [4:0]  BIT_CNT_MAX    = 5'(FRAME_BITS);
  localparam logic [2:0]  BYTE_MOD_OK    = 3'h0;

  typedef logic [FRAME_BITS-1:0] odspi_word_t;
  typedef enum logic [1:0] {LINK_IDLE, LINK_TERWIN, LINK_SHIFT} odspi_link_e;
endpackage : odspi_pkg

// ---- src/odspi_buf_if.sv ----
// Valid and ready channel that carries accepted command words.
`timescale 1ns/100ps
interface odspi_buf_if;
  import odspi_pkg::*;
  odspi_word_t data;
  logic        valid;
  logic        ready;
  modport prod (output data, output valid, input ready);
  modport cons (input data, input valid, output ready);
endinterface : odspi_buf_if

// ---- src/odspi_buf.sv ----
// Two-entry buffer between frame acceptance and the command register.
`timescale 1ns/100ps
module odspi_buf (
  // Clock and flush
  input  wire logic  mclk,
  input  wire logic  clr,
  // Filling and draining sides
  odspi_buf_if.cons  inPort,
  odspi_buf_if.prod  outPort
);
  import odspi_pkg::*;

  odspi_word_t mem [BUF_DEPTH];
  logic        wrPtr;
  logic        rdPtr;
  logic [1:0]  count;
  logic        push;
  logic        pop;

  assign inPort.ready  = (count != 2'(BUF_DEPTH));
  assign outPort.valid = (count != 2'h0);
  assign outPort.data  = mem[rdPtr];
  assign push          = inPort.valid & inPort.ready;
  assign pop           = outPort.valid & outPort.ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr] <= inPort.data;
    end
  end

  always_ff @(posedge mclk) begin
    if (clr) begin
      wrPtr <= 1'h0;
      rdPtr <= 1'h0;
      count <= 2'h0;
    end else begin
      wrPtr <= wrPtr ^ push;
      rdPtr <= rdPtr ^ pop;
      count <= count + 2'(push) - 2'(pop);
    end
  end
endmodule : odspi_buf

// ---- src/odspi_top.sv ----
// Serial control and fault report port of an eight-channel low-side driver.
`timescale 1ns/100ps
// Function
// - Standby clears one channel; resets, limp exit and enable low outside limp-home clear all.
// - Each accepted frame ends in a 16-bit word of eight 2-bit channel commands.
// - Reply frame carries two fault status bits per channel.
// - Words are 16 bits, most significant bit first.
// - Over-load latches the output off until cleared over the port.
// - Over-load must persist a filter delay before shutdown.
// - Limp-home keeps protection, ignores commands, still reports faults.
// - Frame error set when bit count is not n*8 or below 16.
// - Frame error shown on data out from select fall to first rise.
// - Frame error also set leaving lockout, limp-home or low-current mode.
// - Frame error cleared by a command of valid length.
// - Error window drives flag OR data in; afterwards the shift register.
// - Error status readable by select fall alone, no clocks.
// - Data in is sampled on each falling serial clock edge.
// - Next data out bit is driven on each rising serial clock edge.
// - Input register loads only on valid frame length, else unchanged.
// - Bit counter armed on select fall, advanced on rising clock.
// - First 16 bits out are faults; later bits pass through delayed 16.
// - Clock and data ignored unless select is low.
// - Codes 00 standby, 01 parallel input, 10 on, 11 off.
// - Over-load flags on even bits, open-load on odd, channel one lowest.
// - Input register bits are all one after power-on reset.
module odspi_top (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          srst,
  // Serial link pins
  input  wire logic                          sclkPin,
  input  wire logic                          chipSelectN,
  input  wire logic                          serIn,
  output logic                               serOut,
  output logic                               serOutEn,
  // Supply and mode pins
  input  wire logic                          logicSupplyPor,
  input  wire logic                          analogSupplyPor,
  input  wire logic                          undervoltageLockout,
  input  wire logic                          enable,
  input  wire logic                          fallbackDriveInput,
  input  wire logic [odspi_pkg::IN_NUM-1:0]  parallelIn,
  // Channel sense inputs
  input  wire logic [odspi_pkg::CH_NUM-1:0]  overloadSense,
  input  wire logic [odspi_pkg::CH_NUM-1:0]  overTempSense,
  input  wire logic [odspi_pkg::CH_NUM-1:0]  openLoadSense,
  // Command drain stall
  input  wire logic                          applyHold,
  // Channel and status outputs
  output logic [odspi_pkg::CH_NUM-1:0]       drive,
  output logic [odspi_pkg::CH_NUM-1:0]       diagCurrentEn,
  output odspi_pkg::odspi_word_t             cmdWord,
  output logic                               frameErrorFlag,
  output logic                               cmdBufFull
);
  import odspi_pkg::*;
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int ASYNC_W = 8 + IN_NUM + 3 * CH_NUM;
  logic [ASYNC_W-1:0] syncA;
  logic [ASYNC_W-1:0] syncB;
  logic [ASYNC_W-1:0] prevB;
  always_ff @(posedge mclk) begin
    syncA <= {sclkPin, chipSelectN, serIn, logicSupplyPor, analogSupplyPor,
              undervoltageLockout, enable, fallbackDriveInput, parallelIn,
              overloadSense, overTempSense, openLoadSense};
    syncB <= syncA;
    prevB <= syncB;
  end
  logic              sclkS, csnS, siS, lpS, apS, uvS, enS, limp;
  logic              sclkP, csnP, uvP, enP, limpP;
  logic [IN_NUM-1:0] parS;
  logic [CH_NUM-1:0] ovlS, otS, olS;
  assign {sclkS, csnS, siS, lpS, apS, uvS, enS, limp, parS, ovlS, otS, olS}
         = syncB;
  assign sclkP = prevB[ASYNC_W-1];
  assign csnP  = prevB[ASYNC_W-2];
  assign uvP   = prevB[ASYNC_W-6];
  assign enP   = prevB[ASYNC_W-7];
  assign limpP = prevB[ASYNC_W-8];
  logic csLow, csFall, csRise, sclkRise, sclkFall;
  logic porAny, limpExit, uvExit, lowIqExit, clrAll;
  assign csLow     = ~csnS;
  assign csFall    = csnP & ~csnS;
  assign csRise    = ~csnP & csnS;
  assign sclkRise  = csLow & sclkS & ~sclkP;
  assign sclkFall  = csLow & ~sclkS & sclkP;
  assign porAny    = lpS | apS;
  assign limpExit  = limpP & ~limp;
  assign uvExit    = uvP & ~uvS;
  assign lowIqExit = ~enP & enS & ~limp;
  assign clrAll    = porAny | (~enS & ~limp) | limpExit;

  // ----------------------------------------------------------------
  // Link sequencing
  // ----------------------------------------------------------------
  odspi_link_e linkState;
  odspi_link_e next_linkState;
  always_comb begin
    next_linkState = linkState;
    case (linkState)
      LINK_IDLE: begin
        if (csFall) next_linkState = LINK_TERWIN;
      end
      LINK_TERWIN: begin
        if (csRise) next_linkState = LINK_IDLE;
        else if (sclkRise) next_linkState = LINK_SHIFT;
      end
      LINK_SHIFT: begin
        if (csRise) next_linkState = LINK_IDLE;
      end
      default: next_linkState = LINK_IDLE;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      linkState <= LINK_IDLE;
    end else begin
      linkState <= next_linkState;
    end
  end

  // ----------------------------------------------------------------
  // Shift path and frame length check
  // ----------------------------------------------------------------
  odspi_word_t shiftReg;
  odspi_word_t faultWord;
  logic        outBit;
  logic [4:0]  bitCnt;
  logic [2:0]  bitMod;
  logic        frameOk;
  // Each falling edge moves one received bit in at the low end, so the
  // fault word leaves first and any later bits come out sixteen clocks on.
  always_ff @(posedge mclk) begin
    if (srst) begin
      shiftReg <= '0;
    end else if (csFall) begin
      shiftReg <= faultWord;
    end else if (sclkFall) begin
      shiftReg <= {shiftReg[FRAME_BITS-2:0], siS};
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      outBit <= 1'h0;
    end else if (sclkRise) begin
      outBit <= shiftReg[FRAME_BITS-1];
    end
  end
  always_ff @(posedge mclk) begin
    if (srst || csFall) begin
      bitCnt <= '0;
      bitMod <= '0;
    end else if (sclkRise) begin
      bitMod <= bitMod + 3'h1;
      if (bitCnt != BIT_CNT_MAX) begin
        bitCnt <= bitCnt + 5'h1;
      end
    end
  end
  assign frameOk = bitCnt == BIT_CNT_MAX && bitMod == BYTE_MOD_OK;
  // Set events win over the clear of a good frame in the same cycle.
  always_ff @(posedge mclk) begin
    if (srst) begin
      frameErrorFlag <= TER_RESET;
    end else if ((csRise && !frameOk) || uvExit || limpExit || lowIqExit
                 || porAny) begin
      frameErrorFlag <= 1'h1;
    end else if (csRise && frameOk) begin
      frameErrorFlag <= 1'h0;
    end
  end
  // The flag is ORed with data in so an upstream error ripples down the
  // chain; deselect drops the pin before the sequencer has seen it.
  always_ff @(posedge mclk) begin
    if (srst) begin
      serOut   <= 1'h0;
      serOutEn <= 1'h0;
    end else begin
      serOutEn <= csLow;
      case (csLow ? linkState : LINK_IDLE)
        LINK_TERWIN: serOut <= frameErrorFlag | siS;
        LINK_SHIFT:  serOut <= outBit;
        default:     serOut <= 1'h0;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Command buffering and input register
  // ----------------------------------------------------------------
  odspi_buf_if bufIn ();
  odspi_buf_if bufOut ();
  logic frameValid;
  logic cmdWritten;
  // A frame arriving while both entries are full is dropped and counts as
  // a transmission error only by its own length; the full flag warns first.
  assign frameValid   = csRise && frameOk && !limp;
  assign bufIn.valid  = frameValid;
  assign bufIn.data   = shiftReg;
  assign bufOut.ready = ~applyHold;
  odspi_buf odspi_buf_inst (
    .mclk    (mclk),
    .clr     (srst | porAny | limpExit),
    .inPort  (bufIn),
    .outPort (bufOut)
  );
  always_ff @(posedge mclk) begin
    if (srst || porAny || limpExit) begin
      cmdWord    <= CMD_REG_RESET;
      cmdWritten <= 1'h0;
    end else if (bufOut.valid && bufOut.ready) begin
      cmdWord    <= bufOut.data;
      cmdWritten <= 1'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmdBufFull <= 1'h0;
    end else begin
      cmdBufFull <= ~bufIn.ready;
    end
  end

  // ----------------------------------------------------------------
  // Channel control and fault latching
  // ----------------------------------------------------------------
  function automatic logic odspi_want(input logic [1:0] mode,
                                      input logic pin);
    case (mode)
      CMD_INPUT: odspi_want = pin;
      CMD_ON:    odspi_want = 1'h1;
      default:   odspi_want = 1'h0;
    endcase
  endfunction : odspi_want
  logic [CH_NUM-1:0] overFault, openFault, setOver, setOpen, clrCh;
  logic [CH_NUM-1:0] next_drive, next_diag;
  logic [7:0]        ovlCnt [CH_NUM];
  for (genvar ch = 0; ch < CH_NUM; ch++) begin : g_ch
    logic [1:0] mode;
    logic       pin;
    logic       want;
    logic       ovlHit;
    assign mode   = cmdWord[2*ch +: 2];
    assign pin    = parS[ch % IN_NUM];
    assign want   = limp ? ((ch < IN_NUM) && pin)
                         : (enS && !uvS && odspi_want(mode, pin));
    assign ovlHit = drive[ch] & ovlS[ch];
    always_ff @(posedge mclk) begin
      if (srst || !ovlHit) begin
        ovlCnt[ch] <= '0;
      end else if (ovlCnt[ch] != OVL_CNT_MAX) begin
        ovlCnt[ch] <= ovlCnt[ch] + 8'h1;
      end
    end
    assign setOver[ch] = (ovlHit && ovlCnt[ch] == OVL_CNT_MAX - 8'h1)
                         || otS[ch];
    assign setOpen[ch] = !drive[ch] && diagCurrentEn[ch] && olS[ch];
    assign clrCh[ch]   = clrAll || (!limp && mode == CMD_STANDBY);
    assign next_drive[ch] = want && !overFault[ch] && !setOver[ch];
    assign next_diag[ch]  = !limp && ((mode == CMD_INPUT)
                            || (mode == CMD_OFF && cmdWritten));
    assign faultWord[2*ch]     = overFault[ch];
    assign faultWord[2*ch + 1] = openFault[ch];
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      overFault <= '0;
      openFault <= '0;
    end else begin
      overFault <= (overFault & ~clrCh) | setOver;
      openFault <= (openFault & ~clrCh) | setOpen;
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      drive         <= '0;
      diagCurrentEn <= '0;
    end else begin
      drive         <= next_drive;
      diagCurrentEn <= next_diag;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  ter_window_a:
    assert property (linkState == LINK_TERWIN && csLow
                     |=> serOut == $past(frameErrorFlag | siS))
    else $error("error window output wrong");
  shift_out_a:
    assert property (linkState == LINK_SHIFT && csLow
                     |=> serOut == $past(outBit))
    else $error("shifted output wrong");
  bad_frame_a:
    assert property (csRise && !frameOk |=> frameErrorFlag)
    else $error("bad frame did not flag error");
  no_load_a:
    assert property (csRise && !frameOk && !bufOut.valid |=> !bufOut.valid)
    else $error("bad frame accepted");
  limp_ignore_a:
    assert property (limp && !bufOut.valid |=> !bufOut.valid)
    else $error("command taken in limp home");
  latched_off_a:
    assert property (overFault[0] |=> !drive[0])
    else $error("faulted channel driven");
  ovl_filter_a:
    assert property (!overFault[0] && !otS[0] && !clrAll
                     && ovlCnt[0] != OVL_CNT_MAX - 8'h1 |=> !overFault[0])
    else $error("over-load latched before filter time");
  std_clear_a:
    assert property (!limp && cmdWord[1:0] == CMD_STANDBY && !setOver[0]
                     |=> !overFault[0])
    else $error("standby did not clear fault");
  cnt_arm_a:
    assert property (csFall |=> bitCnt == 5'h0 && bitMod == 3'h0)
    else $error("bit counter not armed");
  idle_out_a:
    assert property (!csLow |=> !serOutEn && !serOut)
    else $error("output active while deselected");
  en_follow_a:
    assert property (csLow |=> serOutEn)
    else $error("output not enabled while selected");
  frame_clear_a:
    assert property (csRise && frameOk && !uvExit && !limpExit && !lowIqExit
                     && !porAny |=> !frameErrorFlag)
    else $error("good frame did not clear error");
endmodule : odspi_top

// ---- bench/odspi_host_model.sv ----
// Behavioural host that drives the serial link of the driver port.
`timescale 1ns/100ps
module odspi_host_model (
  // Clock and return data
  input  wire logic   mclk,
  input  wire logic   serOut,
  input  wire logic   slow,
  // Serial link drive
  output logic        sclkPin,
  output logic        chipSelectN,
  output logic        serIn,
  // Captured data
  output logic [63:0] rxData,
  output logic        errBit
);
  initial begin
    sclkPin     = 1'b0;
    chipSelectN = 1'b1;
    serIn       = 1'b0;
    rxData      = '0;
    errBit      = 1'b0;
  end

  task automatic wait_neg(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_neg

  // ----------------------------------------------------------------
  // Frames
  // ----------------------------------------------------------------
  // Half periods are whole system clocks, so pins move on falling edges.
  task automatic xfer(input int nBits, input logic [63:0] txData);
    int half;
    half = slow ? 8 : 4;
    serIn = 1'b0;
    wait_neg(4);
    chipSelectN = 1'b0;
    wait_neg(8);
    errBit = serOut;
    rxData = '0;
    for (int i = nBits - 1; i >= 0; i--) begin
      sclkPin = 1'b1;
      wait_neg(half / 2);
      serIn = txData[i];
      wait_neg(half - half / 2);
      sclkPin = 1'b0;
      rxData = {rxData[62:0], serOut};
      wait_neg(half);
    end
    wait_neg(4);
    chipSelectN = 1'b1;
    // A released data line must not keep showing its last level.
    serIn = ~serIn;
    wait_neg(4);
  endtask : xfer

  task automatic noise();
    repeat (3) begin
      sclkPin = 1'b1;
      serIn   = ~serIn;
      wait_neg(4);
      sclkPin = 1'b0;
      wait_neg(4);
    end
  endtask : noise
endmodule : odspi_host_model

// ---- bench/test_odspi_top.sv ----
// Self-checking testbench of the octal driver serial control port.
`timescale 1ns/100ps
module test_odspi_top;
  import odspi_pkg::*;
  logic        mclk, srst, sclkPin, chipSelectN, serIn, serOut, serOutEn;
  logic        logicSupplyPor, analogSupplyPor, undervoltageLockout;
  logic        enable, fallbackDriveInput, applyHold, frameErrorFlag;
  logic        cmdBufFull, slow, errBit;
  logic [3:0]  parallelIn;
  logic [7:0]  overloadSense, overTempSense, openLoadSense;
  logic [7:0]  drive, diagCurrentEn;
  logic [63:0] rxData;
  odspi_word_t cmdWord;
  int          errorCnt;
  int          checksDone;
  localparam logic [7:0] STEP_CMD [4] = '{8'hee, 8'hbe, 8'hbb, 8'heb};
  localparam logic [3:0] STEP_ON  [4] = '{4'h5, 4'h9, 4'ha, 4'h6};

  odspi_top odspi_top_inst (.mclk, .srst, .sclkPin, .chipSelectN, .serIn,
    .serOut, .serOutEn, .logicSupplyPor, .analogSupplyPor,
    .undervoltageLockout, .enable, .fallbackDriveInput, .parallelIn,
    .overloadSense, .overTempSense, .openLoadSense, .applyHold, .drive,
    .diagCurrentEn, .cmdWord, .frameErrorFlag, .cmdBufFull);

  odspi_host_model odspi_host_model_inst (.mclk, .serOut, .slow, .sclkPin,
    .chipSelectN, .serIn, .rxData, .errBit);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] expd);
    checksDone++;
    if (seen !== expd) begin
      errorCnt++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask : check

  // The command reaches the outputs a few clocks after select rises.
  task automatic xfer(input int nBits, input logic [63:0] txData);
    odspi_host_model_inst.xfer(nBits, txData);
    odspi_host_model_inst.wait_neg(6);
  endtask : xfer

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  initial begin
    idle(50000);
    errorCnt++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    srst                = 1'b1;
    logicSupplyPor      = 1'b0;
    analogSupplyPor     = 1'b0;
    undervoltageLockout = 1'b0;
    enable              = 1'b1;
    fallbackDriveInput  = 1'b0;
    applyHold           = 1'b0;
    parallelIn          = 4'h4;
    overloadSense       = 8'h00;
    overTempSense       = 8'h00;
    openLoadSense       = 8'h00;
    slow                = 1'b0;
    errorCnt            = 0;
    checksDone          = 0;
    idle(10);
    srst = 1'b0;
    idle(4);
    check(cmdWord, 16'hffff);
    check(drive, 8'h00);
    check(diagCurrentEn, 8'h00);
    xfer(0, 0);
    check(errBit, 1'b1);
    check(frameErrorFlag, 1'b1);
    $display("test reset finished");
    xfer(16, 16'he41e);
    check(cmdWord, 16'he41e);
    check(frameErrorFlag, 1'b0);
    check(drive, 8'h45);
    check(diagCurrentEn, 8'ha6);
    for (int n = 8; n < 24; n += 5) begin
      xfer(16, 16'he41e);
      xfer(n, 64'hffff_ffff);
      check(errBit, 1'b0);
      check(cmdWord, 16'he41e);
      check(frameErrorFlag, 1'b1);
    end
    slow = 1'b1;
    xfer(24, 24'hab5aa5);
    slow = 1'b0;
    check(rxData[23:0], 24'h0000ab);
    check(cmdWord, 16'h5aa5);
    xfer(16, 16'he41e);
    $display("test framing finished");
    overTempSense = 8'h01;
    overloadSense = 8'h40;
    idle(100);
    check(drive[6], 1'b1);
    idle(70);
    overTempSense = 8'h00;
    overloadSense = 8'h00;
    idle(10);
    check(drive, 8'h04);
    xfer(16, 16'he41e);
    check(rxData[15:0], 16'h1001);
    check(drive, 8'h04);
    xfer(16, 16'hc41c);
    xfer(16, 16'he41e);
    check(rxData[15:0], 16'h0000);
    check(drive, 8'h45);
    $display("test faults finished");
    overTempSense = 8'h01;
    idle(5);
    overTempSense = 8'h00;
    enable = 1'b0;
    idle(10);
    enable = 1'b1;
    idle(10);
    xfer(16, 16'he41e);
    check(errBit, 1'b1);
    check(rxData[15:0], 16'h0000);
    fallbackDriveInput = 1'b1;
    idle(10);
    xfer(16, 16'h0000);
    check(cmdWord, 16'he41e);
    fallbackDriveInput = 1'b0;
    idle(10);
    check(frameErrorFlag, 1'b1);
    check(cmdWord, 16'hffff);
    xfer(16, 16'he41e);
    undervoltageLockout = 1'b1;
    idle(10);
    undervoltageLockout = 1'b0;
    idle(10);
    check(frameErrorFlag, 1'b1);
    xfer(16, 16'he41e);
    analogSupplyPor = 1'b1;
    idle(5);
    analogSupplyPor = 1'b0;
    idle(5);
    check(cmdWord, 16'hffff);
    xfer(16, 16'he41e);
    logicSupplyPor = 1'b1;
    idle(5);
    logicSupplyPor = 1'b0;
    idle(5);
    check(cmdWord, 16'hffff);
    $display("test modes finished");
    xfer(16, 16'he41e);
    odspi_host_model_inst.noise();
    idle(10);
    check(cmdWord, 16'he41e);
    check(serOutEn, 1'b0);
    applyHold = 1'b1;
    xfer(16, 16'h1111);
    xfer(16, 16'h2222);
    check(cmdBufFull, 1'b1);
    check(cmdWord, 16'he41e);
    xfer(16, 16'h3333);
    applyHold = 1'b0;
    idle(10);
    check(cmdWord, 16'h2222);
    check(cmdBufFull, 1'b0);
    $display("test buffer finished");
    for (int s = 0; s < 4; s++) begin
      xfer(16, {8'hff, STEP_CMD[s]});
      check(drive, {4'h0, STEP_ON[s]});
    end
    $display("test stepper finished");
    end_of_test();
  end
endmodule : test_odspi_top
